// ===== hw/cco_map.svh
`ifndef CCO_MAP_SVH
`define CCO_MAP_SVH
// Opcodes of the two fixed-word instructions (12-bit words)
`define CCO_OP_CLEAR_ACC 12'h040
`define CCO_OP_KICK_WDOG 12'h004
// Invert pattern: top six bits 0010 01, then d, then five-bit address
`define CCO_INV_HI 6'h09
`define CCO_INV_HI_POS 6
`define CCO_DEST_POS 5
`define CCO_ADDR_W 5
`define CCO_REGS 32
`define CCO_ZERO_BYTE 8'h00
`define CCO_ONE_BIT 1'b1
// Watchdog counter width, an assumed value
`define CCO_WDOG_W 8
`define CCO_PRE_W 8
// Status bits come out of reset set
`define CCO_STATUS_RST 1'b1
// Counter step and the top value at which both counters wrap
`define CCO_COUNT_STEP 8'h01
`define CCO_COUNT_TOP 8'hFF
`endif

// ===== hw/cco_pkg.sv
`default_nettype none
package cco_pkg;
  typedef enum logic [1:0] {
    CCO_IDLE = 2'h0,
    CCO_EXEC = 2'h1
  } cco_state_type;
  typedef struct packed {
    logic [7:0] acc;
    logic zero;
    logic expiry;
    logic sleep;
  } cco_core_type;
endpackage
`default_nettype wire

// ===== hw/cco_regfile.sv
`timescale 1ns/1ns
`default_nettype none
`include "cco_map.svh"
// Small file register memory, registered read port
module cco_regfile
(
  input wire logic clk_sys_i,
  input wire logic [4:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i
);
  logic [7:0] mem_r [0:`CCO_REGS-1];

  // Write port
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
      mem_r[wr_addr_i] <= wr_data_i;
  end

  // Registered read, one cycle latency
  always_ff @(posedge clk_sys_i)
  begin
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule
`default_nettype wire

// ===== hw/cco_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cco_map.svh"
// Notes on behaviour
// RULE1 - Clear opcode zeroes accumulator, sets zero flag
// RULE2 - Kick opcode resets watchdog counter to zero
// RULE3 - Kick clears prescaler only if watchdog-assigned
// RULE4 - Kick sets expiry and sleep status bits
// RULE5 - Invert opcode complements addressed file register
// RULE6 - Destination bit picks accumulator or register
// RULE7 - Zero flag follows inverted result
module cco_top
  import cco_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [11:0] instr_i,
  input wire logic pre_to_wdog_i,
  input wire logic wdog_tick_i,
  input wire logic [4:0] host_wr_addr_i,
  input wire logic [7:0] host_wr_data_i,
  input wire logic host_wr_en_i,
  output logic [7:0] acc_o,
  output logic zero_o,
  output logic expiry_status_bit_o,
  output logic sleep_status_bit_o,
  output logic [`CCO_WDOG_W-1:0] watchdog_counter_o,
  output logic [`CCO_PRE_W-1:0] prescaler_o,
  output logic busy_o
);
  cco_state_type state_r;
  cco_core_type core_r;
  logic [7:0] rd_data;
  logic [4:0] addr_r;
  logic dest_r;
  logic [7:0] inv_nxt;
  logic wr_back;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic is_clear;
  logic is_kick;
  logic is_inv;
  logic take;
  logic wdog_gate;
  logic wdog_step;
  logic wdog_wrap;

  // Decode of the three instruction words
  assign take = instr_valid_i && (state_r == CCO_IDLE);
  assign is_clear = take && (instr_i == `CCO_OP_CLEAR_ACC); // see RULE1
  assign is_kick = take && (instr_i == `CCO_OP_KICK_WDOG); // see RULE2
  assign is_inv = take && (instr_i[11:`CCO_INV_HI_POS] == `CCO_INV_HI); // see RULE5

  // Invert result is formed from the registered read data
  assign inv_nxt = ~rd_data; // see RULE5
  assign wr_back = (state_r == CCO_EXEC) && dest_r; // see RULE6
  // Write-back has priority; host loads only outside it
  assign wr_addr = wr_back ? addr_r : host_wr_addr_i;
  assign wr_data = wr_back ? inv_nxt : host_wr_data_i;

  // Counter steps per tick, or per prescaler wrap when the watchdog owns it
  assign wdog_gate = pre_to_wdog_i ? (prescaler_o == `CCO_COUNT_TOP) : 1'b1;
  assign wdog_step = wdog_tick_i && !is_kick && wdog_gate;
  // A kick in the same cycle suppresses the wrap, so the set of expiry wins
  assign wdog_wrap = wdog_step && (watchdog_counter_o == `CCO_COUNT_TOP);

  cco_regfile u_rf
  (
    .clk_sys_i(clk_sys_i),
    .rd_addr_i(instr_i[`CCO_ADDR_W-1:0]),
    .rd_data_o(rd_data),
    .wr_en_i(wr_back || host_wr_en_i),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data)
  );

  // Sequencer: the read memory costs one extra clock per invert
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= CCO_IDLE;
      addr_r <= 5'h00;
      dest_r <= 1'b0;
    end
    else if (is_inv)
    begin
      state_r <= CCO_EXEC;
      addr_r <= instr_i[`CCO_ADDR_W-1:0];
      dest_r <= instr_i[`CCO_DEST_POS];
    end
    else
      state_r <= CCO_IDLE;
  end

  // Accumulator and status flags
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      core_r <= '{acc: `CCO_ZERO_BYTE, zero: 1'b0,
        expiry: `CCO_STATUS_RST, sleep: `CCO_STATUS_RST};
    else
    begin
      if (is_clear)
      begin
        core_r.acc <= `CCO_ZERO_BYTE; // see RULE1
        core_r.zero <= `CCO_ONE_BIT; // see RULE1
      end
      else if (is_kick)
      begin
        core_r.expiry <= `CCO_ONE_BIT; // see RULE4
        core_r.sleep <= `CCO_ONE_BIT; // see RULE4
      end
      else if (state_r == CCO_EXEC)
      begin
        if (!dest_r)
          core_r.acc <= inv_nxt; // see RULE6
        core_r.zero <= (inv_nxt == `CCO_ZERO_BYTE); // see RULE7
      end
      // Watchdog expiry drops the bit until the next kick
      if (wdog_wrap)
        core_r.expiry <= 1'b0;
    end
  end

  // Watchdog counter and shared prescaler
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      watchdog_counter_o <= '0;
      prescaler_o <= '0;
    end
    else if (is_kick)
    begin
      watchdog_counter_o <= '0; // see RULE2
      if (pre_to_wdog_i)
        prescaler_o <= '0; // see RULE3
    end
    else if (wdog_tick_i)
    begin
      // Prescaler steps on every tick; counter advances on its wrap when watchdog-owned, else on every tick
      prescaler_o <= prescaler_o + `CCO_COUNT_STEP;
      if (wdog_step)
        watchdog_counter_o <= watchdog_counter_o + `CCO_COUNT_STEP;
    end
  end

  // Registered copies for the outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      busy_o <= 1'b0;
    else
      busy_o <= is_inv;
  end

  assign acc_o = core_r.acc;
  assign zero_o = core_r.zero;
  assign expiry_status_bit_o = core_r.expiry;
  assign sleep_status_bit_o = core_r.sleep;

  // Clear leaves zero in the accumulator with the flag set
  clear_acc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE1
    is_clear |=> (acc_o == `CCO_ZERO_BYTE) && zero_o) else $error("clear failed");

  // Kick zeroes the counter whoever owns the prescaler
  kick_wdog_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE2
    is_kick |=> watchdog_counter_o == '0) else $error("kick failed");

  // Timer-owned prescaler must not move on a kick
  pre_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE3
    is_kick && !pre_to_wdog_i |=> prescaler_o == $past(prescaler_o))
    else $error("prescaler touched");

  pre_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE3
    is_kick && pre_to_wdog_i |=> prescaler_o == '0) else $error("prescaler kept");

  // Both status bits set, the zero flag untouched
  kick_status_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE4
    is_kick |=> expiry_status_bit_o && sleep_status_bit_o && $stable(zero_o))
    else $error("status wrong");

  // Expiry is only visible between a counter wrap and the next kick
  expiry_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE4
    wdog_wrap |=> !expiry_status_bit_o && (watchdog_counter_o == '0))
    else $error("expiry not flagged");

  // Free-running steps while the prescaler belongs to the timer
  wdog_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE2
    wdog_tick_i && !is_kick && !pre_to_wdog_i
    |=> watchdog_counter_o == $past(watchdog_counter_o) + `CCO_COUNT_STEP)
    else $error("counter step wrong");

  pre_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE3
    wdog_tick_i && !is_kick |=> prescaler_o == $past(prescaler_o) + `CCO_COUNT_STEP)
    else $error("prescaler step wrong");

  // Invert steps: take, one exec cycle with read data, then the result
  sequence inv_take_s;
    is_inv ##1 (state_r == CCO_EXEC);
  endsequence
  sequence inv_acc_s;
    is_inv && !instr_i[`CCO_DEST_POS] ##1 1'b1;
  endsequence
  sequence inv_reg_s;
    is_inv && instr_i[`CCO_DEST_POS] ##1 1'b1;
  endsequence

  // Busy marks exactly the exec cycle; the next word is refused there
  busy_exec_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE5
    is_inv |=> busy_o && (state_r == CCO_EXEC)) else $error("exec cycle missing");

  inv_done_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE5
    inv_take_s |=> (state_r == CCO_IDLE) && !busy_o) else $error("exec cycle repeated");

  inv_acc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE6
    inv_acc_s |=> acc_o == ~$past(rd_data)) else $error("invert to acc wrong");

  // Register destination leaves the accumulator alone and writes the file
  inv_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE6
    inv_reg_s |=> $stable(acc_o)) else $error("acc changed");

  inv_wback_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE6
    inv_reg_s |=> u_rf.mem_r[$past(addr_r)] == ~$past(rd_data))
    else $error("write-back wrong");

  // Zero flag follows the result for either destination
  inv_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see RULE7
    state_r == CCO_EXEC |=> zero_o == ($past(rd_data) == 8'hFF))
    else $error("zero flag wrong");
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cco_pkg::*;
  typedef struct {logic [11:0] w; logic [7:0] acc; logic z;} cco_row_type;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [11:0] instr_i = 12'h000;
  logic pre_to_wdog_i = 1'b0;
  logic wdog_tick_i = 1'b0;
  logic [4:0] wa = 5'h00;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0;
  logic [7:0] acc_o, wdc, pre, pre_seen;
  logic zero_o, exp_o, slp_o, busy_o;
  int failures = 0;
  int num_checks = 0;
  // Inverts of regs 3 and 31, clear, then write-back and read-back of reg 3
  cco_row_type rows [6] = '{'{12'h243, 8'hEC, 1'b0}, '{12'h25F, 8'h00, 1'b1},
    '{12'h243, 8'hEC, 1'b0}, '{12'h040, 8'h00, 1'b1}, '{12'h263, 8'h00, 1'b0},
    '{12'h243, 8'h13, 1'b0}};
  // Clock, one inversion per half period
  always #25 clk_sys_i = ~clk_sys_i;
  cco_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pre_to_wdog_i(pre_to_wdog_i), .wdog_tick_i(wdog_tick_i),
    .host_wr_addr_i(wa), .host_wr_data_i(wd), .host_wr_en_i(we), .acc_o(acc_o),
    .zero_o(zero_o), .expiry_status_bit_o(exp_o), .sleep_status_bit_o(slp_o),
    .watchdog_counter_o(wdc), .prescaler_o(pre), .busy_o(busy_o));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One instruction, then a settle gap long enough for the two-cycle invert
  task automatic issue(input logic [11:0] w);
    @(negedge clk_sys_i);
    instr_valid_i = 1'b1;
    instr_i = w;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    we = 1'b1;
    wa = a;
    wd = d;
    @(negedge clk_sys_i);
    we = 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(negedge clk_sys_i);
      wdog_tick_i = 1'b1;
      @(negedge clk_sys_i);
      wdog_tick_i = 1'b0;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk("reset acc", 8'h00, acc_o);
    chk("reset status", 8'h03, {6'h00, exp_o, slp_o});
    chk("reset counters", 8'h00, wdc | pre);
    $display("test reset done");
    wr(5'h03, 8'h13);
    wr(5'h1F, 8'hFF);
    foreach (rows[i])
    begin
      issue(rows[i].w);
      chk("row acc", rows[i].acc, acc_o);
      chk("row zero", {7'h00, rows[i].z}, {7'h00, zero_o});
    end
    $display("test rows done");
    // Timer-owned prescaler must survive the kick
    tick(3);
    chk("timer-owned tick counter", 8'h03, wdc);
    pre_seen = pre;
    issue(12'h004);
    chk("kick counter", 8'h00, wdc);
    chk("kick keeps prescaler", pre_seen, pre);
    chk("kick status", 8'h03, {6'h00, exp_o, slp_o});
    pre_to_wdog_i = 1'b1;
    tick(5);
    issue(12'h004);
    chk("kick clears prescaler", 8'h00, pre);
    // Watchdog-owned prescaler: one counter step per 256 ticks
    tick(256);
    chk("prescaled counter", 8'h01, wdc);
    chk("prescaler wrapped", 8'h00, pre);
    // Counter wrap drops expiry, a kick raises it again
    pre_to_wdog_i = 1'b0;
    tick(255);
    chk("wrap status", 8'h01, {6'h00, exp_o, slp_o});
    chk("wrapped counter", 8'h00, wdc);
    issue(12'h004);
    chk("kick after wrap", 8'h03, {6'h00, exp_o, slp_o});
    $display("test kick done");
    // Clear offered in the exec cycle is dropped, unknown word is ignored
    @(negedge clk_sys_i);
    instr_valid_i = 1'b1;
    instr_i = 12'h243;
    @(negedge clk_sys_i);
    instr_i = 12'h040;
    chk("busy in exec", 8'h01, {7'h00, busy_o});
    issue(12'hFFF);
    chk("refused clear", 8'h13, acc_o);
    chk("refused clear zero", 8'h00, {7'h00, zero_o});
    chk("busy after", 8'h00, {7'h00, busy_o});
    $display("test refuse done");
    test_done();
  end
  // Watchdog sized well past the roughly 1100 cycles the tests take
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
